// [rtl/adcpc_pkg.sv]
// Package of constants, types and register map for the converter control block.
// Operation
// - Low pin register covers channels 0-7.
// - Middle pin register covers channels 8-15.
// - High pin register covers channels 16-23.
// - Bit one hands pin to analog input.
// - Selected pin output driver forced off.
// - Selected pin input buffer off, reads zero.
// - Selected pin pull-up forced off.
// - Disabled in reset or channel all ones.
// - Idle after completion is lowest power.
// - Raw result 12 bits, 9 in 8-bit.
// - Round to 10 or 8 bits.
// - Set complete flag, interrupt if enabled.
// - Compare only while compare enable set.
// - Four clock sources, bus clock after reset.
// - Bus clock halved source, up to 16.
// - Internal clock keeps running in wait, light stop.
// - Post-divider of 1, 2, 4 or 8.
// - Source codes: bus, half, alternate, internal.
// - Divide codes: 1, 2, 4, 8.
// - Resolution codes: 8, 12, 10, reserved.
package adcpc_pkg;

    localparam int ADCPC_ADDR_W = 8;
    localparam int ADCPC_NUM_CH = 24;

    localparam logic [7:0] ADCPC_OFF_CTRL = 8'h00;
    localparam logic [7:0] ADCPC_OFF_CFG = 8'h04;
    localparam logic [7:0] ADCPC_OFF_RES_HI = 8'h08;
    localparam logic [7:0] ADCPC_OFF_RES_LO = 8'h0C;
    localparam logic [7:0] ADCPC_OFF_CMP_HI = 8'h10;
    localparam logic [7:0] ADCPC_OFF_CMP_LO = 8'h14;
    localparam logic [7:0] ADCPC_OFF_PIN_LO = 8'h18;
    localparam logic [7:0] ADCPC_OFF_PIN_MID = 8'h1C;
    localparam logic [7:0] ADCPC_OFF_PIN_HI = 8'h20;

    localparam logic [4:0] ADCPC_CHAN_OFF = 5'h1F;
    localparam logic [7:0] ADCPC_PIN_RESET = 8'h00;
    localparam logic [3:0] ADCPC_SAMPLE_TICKS = 4'h4;
    localparam logic [3:0] ADCPC_MSB_WIDE = 4'hB;
    localparam logic [3:0] ADCPC_MSB_NARROW = 4'h8;

    typedef enum logic [1:0] {
        ADCPC_SRC_BUS = 2'h0,
        ADCPC_SRC_BUS_HALF = 2'h1,
        ADCPC_SRC_ALT = 2'h2,
        ADCPC_SRC_ASYNC = 2'h3
    } adcpc_src_type;

    typedef enum logic [1:0] {
        ADCPC_DIV_1 = 2'h0,
        ADCPC_DIV_2 = 2'h1,
        ADCPC_DIV_4 = 2'h2,
        ADCPC_DIV_8 = 2'h3
    } adcpc_div_type;

    typedef enum logic [1:0] {
        ADCPC_MODE_8 = 2'h0,
        ADCPC_MODE_12 = 2'h1,
        ADCPC_MODE_10 = 2'h2,
        ADCPC_MODE_RSVD = 2'h3
    } adcpc_mode_type;

    // Control word: bit 8 reads the complete flag, written bits 7..0.
    typedef struct packed {
        logic irq_en;
        logic cmp_en;
        logic cmp_ge;
        logic [4:0] chan;
    } adcpc_ctrl_type;

    typedef struct packed {
        logic low_power;
        adcpc_div_type div;
        logic long_sample;
        adcpc_mode_type mode;
        adcpc_src_type src;
    } adcpc_cfg_type;

    localparam adcpc_ctrl_type ADCPC_CTRL_RESET = '{1'b0, 1'b0, 1'b0, 5'h1F};
    localparam adcpc_cfg_type ADCPC_CFG_RESET =
        '{1'b0, ADCPC_DIV_1, 1'b0, ADCPC_MODE_8, ADCPC_SRC_BUS};

endpackage

// [rtl/adcpc_clkgen.sv]
// Converter clock source selection and post-divider, as a tick enable.
`timescale 1ns/1ps
module adcpc_clkgen
    import adcpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire adcpc_src_type src,
    input wire adcpc_div_type div,
    input wire logic run,
    input wire logic alt_tick,
    input wire logic osc_tick,
    output logic conv_tick
);

    logic half_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic src_tick;
    logic [2:0] div_mask;

    // Sources are reduced to one-cycle ticks so the whole block stays on mclk.
    assign src_tick = (src == ADCPC_SRC_BUS) ? 1'b1 :
                      (src == ADCPC_SRC_BUS_HALF) ? half_reg :
                      (src == ADCPC_SRC_ALT) ? alt_tick :
                      osc_tick;
    assign div_mask = (div == ADCPC_DIV_1) ? 3'h0 :
                      (div == ADCPC_DIV_2) ? 3'h1 :
                      (div == ADCPC_DIV_4) ? 3'h3 : 3'h7;
    assign conv_tick = run && src_tick && (cnt_reg == div_mask);
    assign cnt_next = !run ? 3'h0 :
                      !src_tick ? cnt_reg :
                      (cnt_reg == div_mask) ? 3'h0 : cnt_reg + 3'h1;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            half_reg <= 1'b0;
            cnt_reg <= 3'h0;
        end else begin
            half_reg <= !half_reg;
            cnt_reg <= cnt_next;
        end
    end

endmodule

// [rtl/adcpc_result.sv]
// Result rounding, compare and store decision.
`timescale 1ns/1ps
module adcpc_result
    import adcpc_pkg::*;
(
    input wire logic [11:0] raw,
    input wire adcpc_mode_type mode,
    input wire logic cmp_en,
    input wire logic cmp_ge,
    input wire logic [11:0] cmp_val,
    output logic store,
    output logic [11:0] value
);

    // Rounds half up and saturates so an all-ones raw code cannot wrap to zero.
    function automatic logic [11:0] adcpc_round(input logic [11:0] r, input logic [3:0] drop);
        logic [11:0] q;
        logic [11:0] top;
        q = r >> drop;
        top = 12'hFFF >> drop;
        adcpc_round = (q == top) ? top : q + {11'h000, r[drop - 4'h1]};
    endfunction

    logic [11:0] rounded;
    logic [11:0] cv;
    logic [11:0] diff;
    logic ge;
    logic met;

    // The nine-bit code is left aligned so that the saturation limit is eight bits wide.
    assign rounded = (mode == ADCPC_MODE_10) ? adcpc_round(raw, 4'h2) :
                     (mode == ADCPC_MODE_8) ? adcpc_round({raw[8:0], 3'h0}, 4'h4) :
                     raw;
    assign cv = (mode == ADCPC_MODE_10) ? {2'h0, cmp_val[9:0]} :
                (mode == ADCPC_MODE_8) ? {4'h0, cmp_val[7:0]} : cmp_val;
    assign ge = rounded >= cv;
    assign met = cmp_ge ? ge : !ge;
    assign diff = rounded - cv;
    assign store = !cmp_en || met;
    assign value = cmp_en ? (diff & (cv | rounded | 12'hFFF) & ((mode == ADCPC_MODE_8) ?
                   12'h0FF : (mode == ADCPC_MODE_10) ? 12'h3FF : 12'hFFF)) : rounded;

endmodule

// [rtl/adcpc_top.sv]
// Converter control top: APB registers, pin takeover, sequencing and result store.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module adcpc_top
    import adcpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADCPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ADCPC_NUM_CH-1:0] port_drive_en,
    input wire logic [ADCPC_NUM_CH-1:0] port_pullup_en,
    input wire logic [ADCPC_NUM_CH-1:0] pad_in,
    output logic [ADCPC_NUM_CH-1:0] pad_oe_n,
    output logic [ADCPC_NUM_CH-1:0] pad_pullup_en,
    output logic [ADCPC_NUM_CH-1:0] pad_in_buf_en,
    output logic [ADCPC_NUM_CH-1:0] port_read_data,
    input wire logic alt_tick,
    input wire logic osc_tick,
    input wire logic wait_mode,
    input wire logic light_stop,
    input wire logic deep_stop,
    input wire logic sar_cmp_hi,
    output logic [11:0] sar_dac_code,
    output logic [4:0] sar_channel,
    output logic sar_sampling,
    output logic sar_powered,
    output logic sar_low_power,
    output logic osc_enable,
    output logic conv_irq
);

    typedef enum logic [1:0] {
        ADCPC_ST_IDLE,
        ADCPC_ST_SAMPLE,
        ADCPC_ST_APPROX
    } adcpc_state_type;

    adcpc_state_type state_reg;
    adcpc_state_type state_next;
    adcpc_ctrl_type ctrl_reg;
    adcpc_cfg_type cfg_reg;
    logic [7:0] pin_lo_reg;
    logic [7:0] pin_mid_reg;
    logic [7:0] pin_hi_reg;
    logic [11:0] cmp_reg;
    logic [11:0] res_reg;
    logic done_reg;
    logic [11:0] sar_reg;
    logic [11:0] sar_next;
    logic [3:0] bit_reg;
    logic [3:0] bit_next;
    logic [3:0] smp_reg;
    logic [3:0] smp_next;
    logic [31:0] prdata_reg;

    logic wr;
    logic rd;
    logic hit;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_cmp;
    logic rd_res_lo;
    logic [31:0] rd_mux;
    logic [ADCPC_NUM_CH-1:0] analog_sel;
    logic chan_on;
    logic start;
    logic abort;
    logic tick;
    logic run;
    logic [3:0] msb;
    logic [11:0] trial;
    logic last_bit;
    logic finish;
    logic store;
    logic [11:0] value;
    logic set_done;
    logic clr_done;

    // APB decode; the slave always answers in the first access cycle.
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign hit = (paddr == ADCPC_OFF_CTRL) || (paddr == ADCPC_OFF_CFG) ||
                 (paddr == ADCPC_OFF_RES_HI) || (paddr == ADCPC_OFF_RES_LO) ||
                 (paddr == ADCPC_OFF_CMP_HI) || (paddr == ADCPC_OFF_CMP_LO) ||
                 (paddr == ADCPC_OFF_PIN_LO) || (paddr == ADCPC_OFF_PIN_MID) ||
                 (paddr == ADCPC_OFF_PIN_HI);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_reg;
    assign wr_ctrl = wr && (paddr == ADCPC_OFF_CTRL);
    assign wr_cfg = wr && (paddr == ADCPC_OFF_CFG);
    assign wr_cmp = wr && ((paddr == ADCPC_OFF_CMP_HI) || (paddr == ADCPC_OFF_CMP_LO));
    assign rd_res_lo = rd && (paddr == ADCPC_OFF_RES_LO);

    assign rd_mux = (paddr == ADCPC_OFF_CTRL) ? {23'h00_0000, done_reg, ctrl_reg} :
                    (paddr == ADCPC_OFF_CFG) ? {24'h00_0000, cfg_reg} :
                    (paddr == ADCPC_OFF_RES_HI) ? {28'h000_0000, res_reg[11:8]} :
                    (paddr == ADCPC_OFF_RES_LO) ? {24'h00_0000, res_reg[7:0]} :
                    (paddr == ADCPC_OFF_CMP_HI) ? {28'h000_0000, cmp_reg[11:8]} :
                    (paddr == ADCPC_OFF_CMP_LO) ? {24'h00_0000, cmp_reg[7:0]} :
                    (paddr == ADCPC_OFF_PIN_LO) ? {24'h00_0000, pin_lo_reg} :
                    (paddr == ADCPC_OFF_PIN_MID) ? {24'h00_0000, pin_mid_reg} :
                    (paddr == ADCPC_OFF_PIN_HI) ? {24'h00_0000, pin_hi_reg} :
                    32'h0000_0000;

    // Pin takeover is purely combinational so the pad follows the register bit at once.
    assign analog_sel = {pin_hi_reg, pin_mid_reg, pin_lo_reg};
    assign pad_oe_n = ~(port_drive_en & ~analog_sel);
    assign pad_in_buf_en = ~analog_sel;
    assign port_read_data = pad_in & ~analog_sel;
    assign pad_pullup_en = port_pullup_en & ~analog_sel;

    // Sequencing: channel-on control write restarts; channel-off, config or compare write, deep stop, or wait or light stop off the internal clock aborts.
    assign chan_on = (pwdata[4:0] != ADCPC_CHAN_OFF);
    assign start = wr_ctrl && chan_on;
    assign abort = (wr_ctrl && !chan_on) || wr_cfg || wr_cmp ||
                   (deep_stop && (cfg_reg.src == ADCPC_SRC_ASYNC)) ||
                   ((wait_mode || light_stop || deep_stop) && (cfg_reg.src != ADCPC_SRC_ASYNC));
    assign run = (state_reg != ADCPC_ST_IDLE);
    assign msb = (cfg_reg.mode == ADCPC_MODE_8) ? ADCPC_MSB_NARROW : ADCPC_MSB_WIDE;
    assign trial = sar_reg | (12'h001 << bit_reg);
    assign last_bit = (bit_reg == 4'h0);
    assign finish = (state_reg == ADCPC_ST_APPROX) && tick && last_bit;

    always_comb begin
        state_next = state_reg;
        sar_next = sar_reg;
        bit_next = bit_reg;
        smp_next = smp_reg;
        unique case (state_reg)
            ADCPC_ST_IDLE: begin
            end
            ADCPC_ST_SAMPLE: begin
                if (tick) begin
                    smp_next = smp_reg + 4'h1;
                    if (smp_reg == ADCPC_SAMPLE_TICKS - 4'h1) begin
                        state_next = ADCPC_ST_APPROX;
                    end
                end
            end
            ADCPC_ST_APPROX: begin
                if (tick) begin
                    sar_next = sar_cmp_hi ? trial : sar_reg;
                    bit_next = bit_reg - 4'h1;
                    if (last_bit) begin
                        state_next = ADCPC_ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ADCPC_ST_IDLE;
            end
        endcase
        if (abort) begin
            state_next = ADCPC_ST_IDLE;
        end
        if (start) begin
            state_next = ADCPC_ST_SAMPLE;
            sar_next = 12'h000;
            bit_next = msb;
            smp_next = 4'h0;
        end
    end

    adcpc_clkgen u_clkgen (
        .mclk(mclk),
        .nrst(nrst),
        .src(cfg_reg.src),
        .div(cfg_reg.div),
        .run(run),
        .alt_tick(alt_tick),
        .osc_tick(osc_tick),
        .conv_tick(tick)
    );

    adcpc_result u_result (
        .raw(sar_cmp_hi ? trial : sar_reg),
        .mode(cfg_reg.mode),
        .cmp_en(ctrl_reg.cmp_en),
        .cmp_ge(ctrl_reg.cmp_ge),
        .cmp_val(cmp_reg),
        .store(store),
        .value(value)
    );

    // The flag is set only when a result is actually stored; a set beats a clear.
    assign set_done = finish && store;
    assign clr_done = wr_ctrl || rd_res_lo;

    // The internal oscillator runs only while converting, and wait or light stop do not stop it.
    assign osc_enable = run && (cfg_reg.src == ADCPC_SRC_ASYNC);
    assign sar_powered = run;
    assign sar_sampling = (state_reg == ADCPC_ST_SAMPLE);
    assign sar_dac_code = trial;
    assign sar_channel = ctrl_reg.chan;
    assign sar_low_power = cfg_reg.low_power;
    assign conv_irq = done_reg && ctrl_reg.irq_en;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= ADCPC_CTRL_RESET;
            cfg_reg <= ADCPC_CFG_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= adcpc_ctrl_type'(pwdata[7:0]);
        end else if (wr_cfg) begin
            cfg_reg <= adcpc_cfg_type'(pwdata[7:0]);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_lo_reg <= ADCPC_PIN_RESET;
            pin_mid_reg <= ADCPC_PIN_RESET;
            pin_hi_reg <= ADCPC_PIN_RESET;
        end else if (wr) begin
            pin_lo_reg <= (paddr == ADCPC_OFF_PIN_LO) ? pwdata[7:0] : pin_lo_reg;
            pin_mid_reg <= (paddr == ADCPC_OFF_PIN_MID) ? pwdata[7:0] : pin_mid_reg;
            pin_hi_reg <= (paddr == ADCPC_OFF_PIN_HI) ? pwdata[7:0] : pin_hi_reg;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmp_reg <= 12'h000;
        end else if (wr && (paddr == ADCPC_OFF_CMP_HI)) begin
            cmp_reg <= {pwdata[3:0], cmp_reg[7:0]};
        end else if (wr && (paddr == ADCPC_OFF_CMP_LO)) begin
            cmp_reg <= {cmp_reg[11:8], pwdata[7:0]};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_reg <= 12'h000;
            done_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            res_reg <= set_done ? value : res_reg;
            done_reg <= set_done || (done_reg && !clr_done);
            prdata_reg <= (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ADCPC_ST_IDLE;
            sar_reg <= 12'h000;
            bit_reg <= 4'h0;
            smp_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
            smp_reg <= smp_next;
        end
    end

endmodule

// [tb/adcpc_checker.sv]
// Port-level assertions for the converter control top.
`timescale 1ns/1ps
module adcpc_checker
    import adcpc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADCPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [ADCPC_NUM_CH-1:0] port_drive_en,
    input wire logic [ADCPC_NUM_CH-1:0] port_pullup_en,
    input wire logic [ADCPC_NUM_CH-1:0] pad_in,
    input wire logic [ADCPC_NUM_CH-1:0] pad_oe_n,
    input wire logic [ADCPC_NUM_CH-1:0] pad_pullup_en,
    input wire logic [ADCPC_NUM_CH-1:0] pad_in_buf_en,
    input wire logic [ADCPC_NUM_CH-1:0] port_read_data,
    input wire logic wait_mode,
    input wire logic light_stop,
    input wire logic deep_stop,
    input wire logic [4:0] sar_channel,
    input wire logic sar_sampling,
    input wire logic sar_powered,
    input wire logic osc_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic ctrl_wr = psel && penable && pwrite && paddr == ADCPC_OFF_CTRL;
    wire logic quiet = !wait_mode && !light_stop && !deep_stop;
    a_oe_forced: assert property (&(pad_oe_n | pad_in_buf_en))
        else $error("selected pin driver not off");
    a_port_normal: assert property (((pad_oe_n ^ ~port_drive_en) & pad_in_buf_en) == '0)
        else $error("port pin driver not under port control");
    a_read_zero: assert property (port_read_data == (pad_in & pad_in_buf_en))
        else $error("port read of pin wrong");
    a_pullup_off: assert property (pad_pullup_en == (port_pullup_en & pad_in_buf_en))
        else $error("pull-up not gated");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("access not answered");
    a_bad_addr: assert property (psel && penable && paddr > ADCPC_OFF_PIN_HI |-> pslverr)
        else $error("unmapped address not refused");
    a_chan_off: assert property (ctrl_wr && pwdata[4:0] == 5'h1f |=> !sar_powered)
        else $error("converter on with channel off");
    a_start_sample: assert property (ctrl_wr && pwdata[4:0] != 5'h1f && quiet
        |=> sar_powered && sar_sampling && sar_channel == $past(pwdata[4:0]))
        else $error("conversion did not start sampling");
    a_idle_stays: assert property (!sar_powered && !ctrl_wr |=> !sar_powered)
        else $error("left idle without start");
    a_deep_abort: assert property (deep_stop && !ctrl_wr |=> !sar_powered)
        else $error("deep stop did not abort");
    a_osc_gate: assert property (osc_enable |-> sar_powered)
        else $error("oscillator on while idle");
endmodule
bind adcpc_top adcpc_checker chk (.*);

// [tb/adcpc_pad_model.sv]
// Port pads and analog input seen from the converter control block.
`timescale 1ns/1ps
module adcpc_pad_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [23:0] pad_oe_n,
    input wire logic [23:0] pad_pullup_en,
    input wire logic [23:0] port_out,
    input wire logic [11:0] analog_level,
    input wire logic [11:0] sar_dac_code,
    output logic [23:0] pad_in,
    output logic sar_cmp_hi
);
    logic [23:0] float_reg;
    // An undriven pin without pull-up wanders, so a stale value never passes for a match.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            float_reg <= 24'h5a_5a5a;
        end else begin
            float_reg <= ~float_reg;
        end
    end
    assign pad_in = (~pad_oe_n & port_out) | (pad_oe_n & (pad_pullup_en | float_reg));
    assign sar_cmp_hi = analog_level >= sar_dac_code;
endmodule

// [tb/tb_adc_pin_and_clock_control.sv]
// Self-checking bench for the converter control top.
`timescale 1ns/1ps
module tb_adc_pin_and_clock_control;
    import adcpc_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, sar_cmp_hi, sar_sampling, sar_powered, sar_low_power;
    logic osc_enable, conv_irq;
    logic [23:0] port_drive_en = 24'h00_0000;
    logic [23:0] port_pullup_en = 24'h00_0000;
    logic [23:0] port_out = 24'h00_0000;
    logic [23:0] pad_in, pad_oe_n, pad_pullup_en, pad_in_buf_en, port_read_data;
    logic alt_tick = 1'b0;
    logic osc_tick = 1'b0;
    logic wait_mode = 1'b0;
    logic light_stop = 1'b0;
    logic deep_stop = 1'b0;
    logic [11:0] sar_dac_code;
    logic [11:0] analog_level = 12'h7fe;
    logic [4:0] sar_channel;
    int failures = 0;
    int total_checks = 0;
    int tick_cnt = 0;
    logic irq_seen;

    adcpc_top dut (.*);
    adcpc_pad_model pads (.mclk(mclk), .nrst(nrst), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .port_out(port_out), .analog_level(analog_level),
        .sar_dac_code(sar_dac_code), .pad_in(pad_in), .sar_cmp_hi(sar_cmp_hi));

    always #4 mclk = ~mclk;
    // Alternate source ticks every third cycle, internal oscillator every fifth.
    always @(posedge mclk) begin
        tick_cnt <= tick_cnt + 1;
        alt_tick <= (tick_cnt % 3) == 2;
        osc_tick <= osc_enable && ((tick_cnt % 5) == 4);
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic timeout();
        failures++;
        $display("MISMATCH t=%0t wait ran out", $time);
        tally_and_finish();
    endtask

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask

    task automatic run_conv(input logic [7:0] cfg, input logic [7:0] ctrl, output int cyc,
                            output logic flag, output logic [11:0] res);
        logic [31:0] r;
        wr(ADCPC_OFF_CFG, {24'h00_0000, cfg});
        wr(ADCPC_OFF_CTRL, {24'h00_0000, ctrl});
        cyc = -1;
        do begin
            @(negedge mclk);
            cyc++;
        end while (sar_powered === 1'b1 && cyc < 2000);
        if (sar_powered === 1'b1) timeout();
        irq_seen = conv_irq;
        rd(ADCPC_OFF_CTRL, r);
        flag = r[8];
        rd(ADCPC_OFF_RES_HI, r);
        res[11:8] = r[3:0];
        rd(ADCPC_OFF_RES_LO, r);
        res[7:0] = r[7:0];
    endtask

    task automatic test_reset();
        logic [31:0] r;
        for (int i = 0; i < 3; i++) begin
            rd(ADCPC_OFF_PIN_LO + 8'(4 * i), r);
            check(r === 32'h0000_0000, "pin register reset");
        end
        rd(ADCPC_OFF_CFG, r);
        check(r === 32'h0000_0000, "source not bus clock");
        rd(ADCPC_OFF_CTRL, r);
        check(r === 32'h0000_001f && sar_powered === 1'b0, "not disabled");
        $display("test reset done");
    endtask

    task automatic test_pins();
        logic [31:0] r;
        logic e;
        logic [23:0] sel;
        sel = 24'hf0_3c81;
        @(posedge mclk);
        port_drive_en <= 24'ha5_a5a5;
        port_pullup_en <= 24'h3c_ffff;
        port_out <= 24'h5a_0ff0;
        wr(ADCPC_OFF_PIN_LO, 32'h0000_0081);
        wr(ADCPC_OFF_PIN_MID, 32'h0000_003c);
        wr(ADCPC_OFF_PIN_HI, 32'h0000_00f0);
        @(negedge mclk);
        check(pad_oe_n === (~port_drive_en | sel), "driver");
        check(pad_in_buf_en === ~sel, "input buffer");
        check(port_read_data === (pad_in & ~sel), "port read");
        check(pad_pullup_en === (port_pullup_en & ~sel), "pull-up");
        rd(ADCPC_OFF_PIN_MID, r);
        check(r === 32'h0000_003c, "pin readback");
        wr(ADCPC_OFF_PIN_LO, 32'h0000_0000);
        wr(ADCPC_OFF_PIN_MID, 32'h0000_0000);
        wr(ADCPC_OFF_PIN_HI, 32'h0000_0000);
        @(negedge mclk);
        check(pad_oe_n === ~port_drive_en && pad_in_buf_en === '1, "port control");
        apb(1'b0, 8'h30, 32'h0000_0000, r, e);
        check(e === 1'b1 && r === 32'h0000_0000, "unmapped read");
        $display("test pins done");
    endtask

    task automatic test_modes();
        int c;
        logic f;
        logic [11:0] v;
        run_conv(8'h04, 8'h83, c, f, v);
        check(f === 1'b1 && v === 12'h7fe && c == 16, "12-bit");
        check(irq_seen === 1'b1, "irq raised");
        run_conv(8'h08, 8'h03, c, f, v);
        check(f === 1'b1 && v === 12'h200 && c == 16, "10-bit");
        check(irq_seen === 1'b0, "irq masked");
        @(posedge mclk);
        analog_level <= 12'hfff;
        run_conv(8'h00, 8'h03, c, f, v);
        check(f === 1'b1 && v === 12'h0ff && c == 13, "8-bit");
        @(posedge mclk);
        analog_level <= 12'h7fe;
        $display("test modes done");
    endtask

    task automatic test_clocks();
        int c, per;
        logic f;
        logic [11:0] v;
        // Rates stay well inside the converter's range, as software must arrange.
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                per = (s == 0 ? 1 : s == 1 ? 2 : s == 2 ? 3 : 5) << d;
                run_conv({1'b0, 2'(d), 1'b0, 2'b01, 2'(s)}, 8'h03, c, f, v);
                check(c > 15 * per && c <= 17 * per && f === 1'b1, "rate");
            end
        end
        $display("test clocks done");
    endtask

    task automatic test_stop();
        int c;
        logic f;
        logic [11:0] v;
        wr(ADCPC_OFF_CFG, 32'h0000_00e7);
        wr(ADCPC_OFF_CTRL, 32'h0000_0003);
        wait_mode <= 1'b1;
        repeat (100) @(posedge mclk);
        check(sar_powered === 1'b1 && osc_enable === 1'b1, "async in wait");
        check(sar_low_power === 1'b1, "low power cfg");
        wait_mode <= 1'b0;
        deep_stop <= 1'b1;
        @(posedge mclk);
        deep_stop <= 1'b0;
        @(negedge mclk);
        check(sar_powered === 1'b0, "deep stop abort");
        wr(ADCPC_OFF_CMP_HI, 32'h0000_0001);
        wr(ADCPC_OFF_CMP_LO, 32'h0000_0000);
        run_conv(8'h04, 8'h63, c, f, v);
        check(f === 1'b1 && v === 12'h6fe, "compare hit");
        wr(ADCPC_OFF_CMP_HI, 32'h0000_000f);
        run_conv(8'h04, 8'h63, c, f, v);
        check(f === 1'b0, "compare miss");
        run_conv(8'h04, 8'h03, c, f, v);
        check(f === 1'b1 && v === 12'h7fe, "compare off");
        wr(ADCPC_OFF_CTRL, 32'h0000_0003);
        wr(ADCPC_OFF_CTRL, 32'h0000_001f);
        @(negedge mclk);
        check(sar_powered === 1'b0, "channel off");
        $display("test stop done");
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        test_reset();
        test_pins();
        test_modes();
        test_clocks();
        test_stop();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        timeout();
    end
endmodule
